/* File: design/xmii_port_device.sv */
// device end: transmit pin functions of the two external mac ports
module xmii_port_device (
	input wire logic mclk,
	input wire logic rst,
	xmii_tx_if.device pins,
	input wire xmii_pkg::mode_t [xmii_pkg::NUM_PORTS-1:0] mode,
	input wire logic [xmii_pkg::NUM_PORTS-1:0] role_phy,
	input wire logic [xmii_pkg::NUM_PORTS-1:0] rmii_clock_mode,
	input wire logic [xmii_pkg::NUM_PORTS-1:0] collision_req,
	output logic [xmii_pkg::NUM_PORTS-1:0] rx_valid,
	output logic [xmii_pkg::NUM_PORTS-1:0][xmii_pkg::NIB_W-1:0] rx_data,
	output logic [xmii_pkg::NUM_PORTS-1:0] rx_error,
	output logic [xmii_pkg::NUM_PORTS-1:0] frame_active,
	output logic [xmii_pkg::NUM_PORTS-1:0] collision_seen
);

	// every port is an independent copy; nothing is shared between them
	genvar p;
	generate
		for (p = 0; p < xmii_pkg::NUM_PORTS; p++) begin : g_port
			// pin inputs packed for the synchroniser: {txd, col, er, en, ref, clk}
			localparam int SW = xmii_pkg::NIB_W + 5;
			logic [SW-1:0] pin_raw; // raw pin levels, another clock domain
			logic [SW-1:0] sync1; // first stage, read only by sync2
			logic [SW-1:0] sync2; // safe copy of the pins
			logic clk_seen; // previous safe link clock level for edge finding
			logic [xmii_pkg::DIV_W-1:0] div_cnt; // divider for the clock we make
			logic own_clk; // clock this port makes itself
			logic own_rise; // one cycle as own_clk goes high
			logic makes_clk; // this end makes the link clock
			logic in_clk; // the received link clock chosen by mode
			logic sample; // one cycle per link clock rising edge
			logic is_mii; // mode decodes
			logic is_rmii;
			logic dibit_phase; // second rmii dibit is due
			logic [xmii_pkg::DIBIT_W-1:0] low_dibit; // first rmii dibit held

			assign is_mii = (mode[p] == xmii_pkg::MODE_MII);
			assign is_rmii = (mode[p] == xmii_pkg::MODE_RMII);

			// gather the pins; col is only meaningful when we do not drive it
			assign pin_raw = {pins.txd[p], pins.col[p], pins.tx_er[p], pins.tx_en[p],
				pins.rmii_ref_clock_in[p], pins.tx_clk[p]};

			// two flops before any logic looks at an outside pin
			always_ff @(posedge mclk) begin
				if (rst) begin
					sync1 <= '0;
					sync2 <= '0;
				end else begin
					sync1 <= pin_raw;
					sync2 <= sync1;
				end
			end

			// remembers the last safe level of the received clock
			always_ff @(posedge mclk) begin
				if (rst) begin
					clk_seen <= 1'b0;
				end else begin
					clk_seen <= in_clk;
				end
			end

			// who makes the clock depends on this port's own settings alone
			always_comb begin
				makes_clk = 1'b0;
				in_clk = 1'b0;
				unique case (mode[p])
					xmii_pkg::MODE_MII: begin
						makes_clk = role_phy[p];
						in_clk = sync2[0];
					end
					xmii_pkg::MODE_RMII: begin
						makes_clk = rmii_clock_mode[p];
						in_clk = rmii_clock_mode[p] ? 1'b0 : sync2[1];
					end
					xmii_pkg::MODE_RGMII: begin
						makes_clk = 1'b0;
						in_clk = sync2[0];
					end
					default: begin
						// unused code: treat as idle, no clock at all
						makes_clk = 1'b0;
						in_clk = 1'b0;
					end
				endcase
			end

			// divider for the clock this port drives; free running so a mode change
			// never waits on a stuck counter
			always_ff @(posedge mclk) begin
				if (rst) begin
					div_cnt <= xmii_pkg::DIV_RESET;
					own_clk <= 1'b0;
				end else if (div_cnt == xmii_pkg::DIV_LAST) begin
					div_cnt <= xmii_pkg::DIV_RESET;
					own_clk <= ~own_clk;
				end else begin
					div_cnt <= div_cnt + 1'b1;
				end
			end

			assign own_rise = (div_cnt == xmii_pkg::DIV_LAST) && !own_clk;

			// sample on our own rising edge, or a rising edge seen on the safe copy
			assign sample = makes_clk ? own_rise : (in_clk && !clk_seen);

			// clock pin drivers, registered from the divider state
			always_ff @(posedge mclk) begin
				if (rst) begin
					pins.tx_clk_dev_o[p] <= 1'b0;
					pins.tx_clk_dev_oe[p] <= 1'b0;
					pins.rmii_ref_clock_out[p] <= 1'b0;
				end else begin
					// tx clock driven only as mii phy; otherwise it is an input
					pins.tx_clk_dev_oe[p] <= is_mii && role_phy[p];
					pins.tx_clk_dev_o[p] <= is_mii && role_phy[p] && own_clk;
					// reference clock out toggles only in rmii clock mode
					pins.rmii_ref_clock_out[p] <= is_rmii && rmii_clock_mode[p] && own_clk;
				end
			end

			// collision: driven in mii phy role, listened to in mii mac role
			always_ff @(posedge mclk) begin
				if (rst) begin
					pins.col_dev_o[p] <= 1'b0;
					pins.col_dev_oe[p] <= 1'b0;
					collision_seen[p] <= 1'b0;
				end else begin
					pins.col_dev_oe[p] <= is_mii && role_phy[p];
					pins.col_dev_o[p] <= is_mii && role_phy[p] && collision_req[p];
					collision_seen[p] <= is_mii && !role_phy[p] && sync2[4];
				end
			end

			// rmii dibit pairing; a frame gap restarts on the low dibit
			always_ff @(posedge mclk) begin
				if (rst) begin
					dibit_phase <= 1'b0;
					low_dibit <= xmii_pkg::DIBIT_RESET;
				end else if (!is_rmii) begin
					dibit_phase <= 1'b0;
				end else if (sample) begin
					if (!sync2[2]) begin
						dibit_phase <= 1'b0;
					end else if (!dibit_phase) begin
						low_dibit <= sync2[6:5];
						dibit_phase <= 1'b1;
					end else begin
						dibit_phase <= 1'b0;
					end
				end
			end

			// frame capture; enable (or rgmii control) qualifies the data
			always_ff @(posedge mclk) begin
				if (rst) begin
					rx_valid[p] <= 1'b0;
					rx_data[p] <= xmii_pkg::NIB_RESET;
					rx_error[p] <= 1'b0;
					frame_active[p] <= 1'b0;
				end else begin
					rx_valid[p] <= 1'b0;
					if (sample) begin
						frame_active[p] <= sync2[2];
						if (sync2[2]) begin
							if (is_rmii) begin
								// only bits one and zero carry data here
								if (dibit_phase) begin
									rx_valid[p] <= 1'b1;
									rx_data[p] <= {sync2[6:5], low_dibit};
									rx_error[p] <= 1'b0;
								end
							end else begin
								// mii and rgmii use the full nibble
								rx_valid[p] <= 1'b1;
								rx_data[p] <= sync2[8:5];
								// error pin counts only in mii
								rx_error[p] <= is_mii && sync2[3];
							end
						end
					end
				end
			end
		end
	endgenerate

	// reset here is active high by house style; the board's low-active reset
	// pin is inverted outside this block before it reaches rst

endmodule : xmii_port_device

/* File: common/xmii_pkg.sv */
// shared constants and types for the external port transmit pin functions
package xmii_pkg;

	// number of external MAC ports handled side by side
	localparam int NUM_PORTS = 2;
	// full transmit data path width and the reduced rmii path width
	localparam int NIB_W = 4;
	localparam int DIBIT_W = 2;

	// system clock period in ns
	localparam int MCLK_PERIOD_NS = 50;
	// link clock period in ns made by the divider of either end
	localparam int LINK_PERIOD_NS = 400;
	// mclk cycles per link clock half period, rounded down, at least one
	localparam int LINK_HALF_CYCLES = (LINK_PERIOD_NS / (2 * MCLK_PERIOD_NS)) < 1 ? 1 :
		(LINK_PERIOD_NS / (2 * MCLK_PERIOD_NS));
	// divider counter width and its terminal value
	localparam int DIV_W = 4;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LINK_HALF_CYCLES - 1);
	localparam logic [DIV_W-1:0] DIV_RESET = 4'h0;

	// reset values of the pin drivers and captured data
	localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
	localparam logic [DIBIT_W-1:0] DIBIT_RESET = 2'h0;

	// interface modes, gray coded
	typedef enum logic [1:0] {
		MODE_MII = 2'b00,
		MODE_RMII = 2'b01,
		MODE_RGMII = 2'b11
	} mode_t;

endpackage : xmii_pkg

/* File: common/xmii_tx_if.sv */
// transmit side pins of the two external ports, joining the device and its partner
interface xmii_tx_if;

	// transmit clock pin, two-way: device drives it in mii phy role
	logic [xmii_pkg::NUM_PORTS-1:0] tx_clk_dev_o;
	logic [xmii_pkg::NUM_PORTS-1:0] tx_clk_dev_oe;
	logic [xmii_pkg::NUM_PORTS-1:0] tx_clk_par_o;
	logic [xmii_pkg::NUM_PORTS-1:0] tx_clk_par_oe;
	logic [xmii_pkg::NUM_PORTS-1:0] tx_clk;
	// rmii reference clock into the device (partner driven) and out of it
	logic [xmii_pkg::NUM_PORTS-1:0] rmii_ref_clock_in;
	logic [xmii_pkg::NUM_PORTS-1:0] rmii_ref_clock_out;
	// transmit enable / control, error and data, all partner driven
	logic [xmii_pkg::NUM_PORTS-1:0] tx_en;
	logic [xmii_pkg::NUM_PORTS-1:0] tx_er;
	logic [xmii_pkg::NUM_PORTS-1:0][xmii_pkg::NIB_W-1:0] txd;
	// collision pin, two-way: device drives it in mii phy role
	logic [xmii_pkg::NUM_PORTS-1:0] col_dev_o;
	logic [xmii_pkg::NUM_PORTS-1:0] col_dev_oe;
	logic [xmii_pkg::NUM_PORTS-1:0] col_par_o;
	logic [xmii_pkg::NUM_PORTS-1:0] col_par_oe;
	logic [xmii_pkg::NUM_PORTS-1:0] col;

	// resolve the shared wires; an undriven pin reads low like a pull-down
	assign tx_clk = (tx_clk_dev_oe & tx_clk_dev_o) | (tx_clk_par_oe & tx_clk_par_o);
	assign col = (col_dev_oe & col_dev_o) | (col_par_oe & col_par_o);

	modport device (
		input tx_clk, rmii_ref_clock_in, tx_en, tx_er, txd, col,
		output tx_clk_dev_o, tx_clk_dev_oe, rmii_ref_clock_out, col_dev_o, col_dev_oe
	);

	modport partner (
		input tx_clk, rmii_ref_clock_out, col,
		output tx_clk_par_o, tx_clk_par_oe, rmii_ref_clock_in, tx_en, tx_er, txd, col_par_o, col_par_oe
	);

endinterface : xmii_tx_if

/* File: design/xmii_port_partner.sv */
// partner end: external mac or phy driving the device's transmit pins
module xmii_port_partner (
	input wire logic mclk,
	input wire logic rst,
	xmii_tx_if.partner pins,
	input wire xmii_pkg::mode_t [xmii_pkg::NUM_PORTS-1:0] mode,
	input wire logic [xmii_pkg::NUM_PORTS-1:0] role_phy,
	input wire logic [xmii_pkg::NUM_PORTS-1:0] rmii_clock_mode,
	input wire logic [xmii_pkg::NUM_PORTS-1:0] send_valid,
	input wire logic [xmii_pkg::NUM_PORTS-1:0][xmii_pkg::NIB_W-1:0] send_data,
	input wire logic [xmii_pkg::NUM_PORTS-1:0] send_error,
	input wire logic [xmii_pkg::NUM_PORTS-1:0] collision_req,
	output logic [xmii_pkg::NUM_PORTS-1:0] send_ready,
	output logic [xmii_pkg::NUM_PORTS-1:0] collision_seen
);

	genvar p;
	generate
		for (p = 0; p < xmii_pkg::NUM_PORTS; p++) begin : g_port
			logic [2:0] pin_raw; // {col, ref out, tx clk} from the device
			logic [2:0] sync1; // first stage, read only by sync2
			logic [2:0] sync2; // safe copy
			logic clk_seen; // previous safe clock level
			logic [xmii_pkg::DIV_W-1:0] div_cnt; // divider for the clock we make
			logic own_clk;
			logic own_fall; // one cycle as own_clk goes low
			logic makes_clk; // this end makes the link clock
			logic in_clk; // the device made clock, safe copy
			logic launch; // one cycle per link clock falling edge
			logic is_mii;
			logic is_rmii;
			logic dibit_phase; // high dibit still to send
			logic [xmii_pkg::DIBIT_W-1:0] high_dibit; // held high dibit

			assign is_mii = (mode[p] == xmii_pkg::MODE_MII);
			assign is_rmii = (mode[p] == xmii_pkg::MODE_RMII);
			assign pin_raw = {pins.col[p], pins.rmii_ref_clock_out[p], pins.tx_clk[p]};

			// two flops before logic reads the device's pins
			always_ff @(posedge mclk) begin
				if (rst) begin
					sync1 <= '0;
					sync2 <= '0;
				end else begin
					sync1 <= pin_raw;
					sync2 <= sync1;
				end
			end

			// we make the clock in mii with a mac device, rgmii and rmii normal
			assign makes_clk = (is_mii && !role_phy[p]) || (mode[p] == xmii_pkg::MODE_RGMII) ||
				(is_rmii && !rmii_clock_mode[p]);
			// otherwise follow the clock the device drives
			assign in_clk = is_rmii ? sync2[1] : sync2[0];

			always_ff @(posedge mclk) begin
				if (rst) begin
					clk_seen <= 1'b0;
				end else begin
					clk_seen <= in_clk;
				end
			end

			// free running divider, same rate as the device's own
			always_ff @(posedge mclk) begin
				if (rst) begin
					div_cnt <= xmii_pkg::DIV_RESET;
					own_clk <= 1'b0;
				end else if (div_cnt == xmii_pkg::DIV_LAST) begin
					div_cnt <= xmii_pkg::DIV_RESET;
					own_clk <= ~own_clk;
				end else begin
					div_cnt <= div_cnt + 1'b1;
				end
			end

			assign own_fall = (div_cnt == xmii_pkg::DIV_LAST) && own_clk;
			// data changes on the falling edge, half a period before sampling
			assign launch = makes_clk ? own_fall : (!in_clk && clk_seen);
			// a nibble is taken at a launch unless rmii still owes its high dibit
			assign send_ready[p] = launch && !(is_rmii && dibit_phase);

			// clock drivers of this end
			always_ff @(posedge mclk) begin
				if (rst) begin
					pins.tx_clk_par_o[p] <= 1'b0;
					pins.tx_clk_par_oe[p] <= 1'b0;
					pins.rmii_ref_clock_in[p] <= 1'b0;
				end else begin
					pins.tx_clk_par_oe[p] <= makes_clk && !is_rmii;
					pins.tx_clk_par_o[p] <= makes_clk && !is_rmii && own_clk;
					pins.rmii_ref_clock_in[p] <= makes_clk && is_rmii && own_clk;
				end
			end

			// collision: we drive it only when the device is an mii mac
			always_ff @(posedge mclk) begin
				if (rst) begin
					pins.col_par_o[p] <= 1'b0;
					pins.col_par_oe[p] <= 1'b0;
					collision_seen[p] <= 1'b0;
				end else begin
					pins.col_par_oe[p] <= is_mii && !role_phy[p];
					pins.col_par_o[p] <= is_mii && !role_phy[p] && collision_req[p];
					collision_seen[p] <= is_mii && role_phy[p] && sync2[2];
				end
			end

			// frame drive: enable, error and data pins, all registered
			always_ff @(posedge mclk) begin
				if (rst) begin
					pins.tx_en[p] <= 1'b0;
					pins.tx_er[p] <= 1'b0;
					pins.txd[p] <= xmii_pkg::NIB_RESET;
					dibit_phase <= 1'b0;
					high_dibit <= xmii_pkg::DIBIT_RESET;
				end else if (launch) begin
					if (is_rmii && dibit_phase) begin
						pins.txd[p] <= {2'h0, high_dibit};
						dibit_phase <= 1'b0;
					end else if (send_valid[p]) begin
						pins.tx_en[p] <= 1'b1;
						// error pin left low outside mii
						pins.tx_er[p] <= is_mii && send_error[p];
						if (is_rmii) begin
							// upper data pins stay quiet in rmii
							pins.txd[p] <= {2'h0, send_data[p][1:0]};
							high_dibit <= send_data[p][3:2];
							dibit_phase <= 1'b1;
						end else begin
							pins.txd[p] <= send_data[p];
						end
					end else begin
						pins.tx_en[p] <= 1'b0;
						pins.tx_er[p] <= 1'b0;
						pins.txd[p] <= xmii_pkg::NIB_RESET;
					end
				end
			end
		end
	endgenerate

endmodule : xmii_port_partner

/* File: tb/xmii_tx_assertions.sv */
// concurrent checks on the transmit pins of both external ports
module xmii_tx_assertions (
	input wire logic mclk,
	input wire logic rst,
	input wire xmii_pkg::mode_t [xmii_pkg::NUM_PORTS-1:0] mode,
	input wire logic [xmii_pkg::NUM_PORTS-1:0] role_phy,
	input wire logic [xmii_pkg::NUM_PORTS-1:0] rmii_clock_mode,
	input wire logic [xmii_pkg::NUM_PORTS-1:0] tx_clk_dev_oe,
	input wire logic [xmii_pkg::NUM_PORTS-1:0] tx_clk_par_oe,
	input wire logic [xmii_pkg::NUM_PORTS-1:0] rmii_ref_clock_in,
	input wire logic [xmii_pkg::NUM_PORTS-1:0] rmii_ref_clock_out,
	input wire logic [xmii_pkg::NUM_PORTS-1:0] tx_er,
	input wire logic [xmii_pkg::NUM_PORTS-1:0][xmii_pkg::NIB_W-1:0] txd,
	input wire logic [xmii_pkg::NUM_PORTS-1:0] col_dev_oe,
	input wire logic [xmii_pkg::NUM_PORTS-1:0] col_par_oe,
	input wire logic [xmii_pkg::NUM_PORTS-1:0] col
);
	// one domain only, so clock and reset are given once
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// each port checked against its own settings, never its neighbour's
	for (genvar p = 0; p < xmii_pkg::NUM_PORTS; p++) begin : g_port
		// mode decode shorthands
		wire mii = (mode[p] == xmii_pkg::MODE_MII);
		wire rmii = (mode[p] == xmii_pkg::MODE_RMII);
		wire rgmii = (mode[p] == xmii_pkg::MODE_RGMII);
		// pin drivers lag config by one cycle after release, hence the past term
		a_phy_clk_out: assert property (!$past(rst) |-> tx_clk_dev_oe[p] == (mii && role_phy[p]))
			else $error("device transmit clock drive wrong");
		a_rgmii_clk_in: assert property (!$past(rst) && rgmii |-> tx_clk_par_oe[p] && !tx_clk_dev_oe[p])
			else $error("rgmii transmit clock not from partner");
		a_ref_out_runs: assert property (rmii && rmii_clock_mode[p] |-> ##[1:12] $changed(rmii_ref_clock_out[p]))
			else $error("reference clock output stalled");
		a_ref_out_idle: assert property (!(rmii && rmii_clock_mode[p]) |-> !rmii_ref_clock_out[p])
			else $error("reference clock output outside clock mode");
		a_ref_in_runs: assert property (rmii && !rmii_clock_mode[p] |-> ##[1:12] $changed(rmii_ref_clock_in[p]))
			else $error("reference clock input stalled");
		a_col_direction: assert property (!$past(rst) |->
			col_dev_oe[p] == (mii && role_phy[p]) && col_par_oe[p] == (mii && !role_phy[p]))
			else $error("collision pin direction wrong");
		a_rmii_upper_idle: assert property (rmii |-> txd[p][3:2] == 2'h0)
			else $error("upper data bits driven in rmii");
		a_er_mii_only: assert property (!mii |-> !tx_er[p])
			else $error("transmit error driven outside mii");
		// main scenarios reached
		c_ref_out: cover property ($rose(rmii_ref_clock_out[p]));
		c_rgmii: cover property (rgmii && tx_clk_par_oe[p]);
		c_col: cover property ($rose(col[p]));
	end
endmodule : xmii_tx_assertions

/* File: tb/tb_top.sv */
// self-checking bench joining device and partner ends over the transmit pins
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; $display("FAIL %s exp %h got %h", n, e, g); end end

	logic mclk; // system clock
	logic rst; // sync reset, active high
	xmii_pkg::mode_t [1:0] mode; // per port interface mode
	logic [1:0] role_phy, rmii_clock_mode; // per port role and rmii clocking
	logic [1:0] send_valid, send_error, send_ready; // partner user side
	logic [1:0][3:0] send_data, rx_data;
	logic [1:0] rx_valid, rx_error, frame_active; // device user side
	logic [1:0] dev_col_req, par_col_req, dev_col_seen, par_col_seen; // collision levels
	logic [4:0] q[2][$]; // model: accepted {error, nibble} per port
	logic [4:0] exp_item;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	// config table: mii phy, mii mac, rmii normal, rmii clock, rgmii
	xmii_pkg::mode_t cfg_mode[5] = '{xmii_pkg::MODE_MII, xmii_pkg::MODE_MII, xmii_pkg::MODE_RMII,
		xmii_pkg::MODE_RMII, xmii_pkg::MODE_RGMII};
	logic cfg_phy[5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
	logic cfg_clk[5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

	xmii_tx_if pins_if ();
	xmii_port_device xmii_port_device_i (.mclk(mclk), .rst(rst), .pins(pins_if.device), .mode(mode),
		.role_phy(role_phy), .rmii_clock_mode(rmii_clock_mode), .collision_req(dev_col_req), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_error(rx_error), .frame_active(frame_active), .collision_seen(dev_col_seen));
	xmii_port_partner xmii_port_partner_i (.mclk(mclk), .rst(rst), .pins(pins_if.partner), .mode(mode),
		.role_phy(role_phy), .rmii_clock_mode(rmii_clock_mode), .send_valid(send_valid), .send_data(send_data),
		.send_error(send_error), .collision_req(par_col_req), .send_ready(send_ready), .collision_seen(par_col_seen));
	xmii_tx_assertions xmii_tx_assertions_i (.mclk(mclk), .rst(rst), .mode(mode), .role_phy(role_phy),
		.rmii_clock_mode(rmii_clock_mode), .tx_clk_dev_oe(pins_if.tx_clk_dev_oe), .tx_clk_par_oe(pins_if.tx_clk_par_oe),
		.rmii_ref_clock_in(pins_if.rmii_ref_clock_in), .rmii_ref_clock_out(pins_if.rmii_ref_clock_out),
		.tx_er(pins_if.tx_er), .txd(pins_if.txd), .col_dev_oe(pins_if.col_dev_oe), .col_par_oe(pins_if.col_par_oe),
		.col(pins_if.col));

	// verdict and end of run, shared by main sequence and timeout
	task automatic report_and_stop;
		if (err_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop

	// 20 mhz system clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// timeout: about four times the planned run
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 10000) begin
			err_count++;
			report_and_stop();
		end
	end

	// model: push each nibble the partner takes, pop one per device capture
	always @(posedge mclk) begin
		for (int p = 0; p < 2; p++) begin
			if (rst) begin
				q[p].delete();
			end else begin
				if (send_valid[p] && send_ready[p]) begin
					// error only travels in mii; elsewhere the pin is dead
					q[p].push_back({send_error[p] && mode[p] == xmii_pkg::MODE_MII, send_data[p]});
					send_data[p] <= 4'($urandom);
					send_error[p] <= 1'($urandom);
				end
				if (rx_valid[p]) begin
					if (q[p].size() == 0) begin
						`CHK("rx_extra", 1'b0, 1'b1)
					end else begin
						exp_item = q[p].pop_front();
						`CHK("rx_data", exp_item[3:0], rx_data[p])
						`CHK("rx_error", exp_item[4], rx_error[p])
					end
				end
			end
		end
	end

	// main sequence: every mode on port 0, a different one on port 1 at once
	initial begin
		void'($urandom(18));
		rst = 1'b1;
		// enum elements are set one by one; a raw vector would need a cast
		mode[0] = xmii_pkg::MODE_MII;
		mode[1] = xmii_pkg::MODE_MII;
		role_phy = '0;
		rmii_clock_mode = '0;
		send_valid = '0;
		send_error = '0;
		send_data = '0;
		dev_col_req = '0;
		par_col_req = '0;
		for (int k = 0; k < 5; k++) begin
			@(posedge mclk);
			rst <= 1'b1;
			mode[0] <= cfg_mode[k];
			mode[1] <= cfg_mode[(k + 2) % 5];
			role_phy <= {cfg_phy[(k + 2) % 5], cfg_phy[k]};
			rmii_clock_mode <= {cfg_clk[(k + 2) % 5], cfg_clk[k]};
			dev_col_req <= 2'($urandom);
			par_col_req <= 2'($urandom);
			send_valid <= 2'b00;
			repeat (8) @(posedge mclk);
			rst <= 1'b0;
			send_valid <= 2'b11;
			repeat (400) @(posedge mclk);
			@(negedge mclk);
			`CHK("frame_active", 2'b11, frame_active)
			for (int p = 0; p < 2; p++) begin
				// collision only crosses in mii, towards the mac side
				`CHK("dev_col", (mode[p] == xmii_pkg::MODE_MII && !role_phy[p]) & par_col_req[p], dev_col_seen[p])
				`CHK("par_col", (mode[p] == xmii_pkg::MODE_MII && role_phy[p]) & dev_col_req[p], par_col_seen[p])
			end
			@(posedge mclk);
			send_valid <= 2'b00;
			repeat (100) @(posedge mclk);
			@(negedge mclk);
			`CHK("frame_end", 2'b00, frame_active)
			`CHK("q0_left", 0, q[0].size())
			`CHK("q1_left", 0, q[1].size())
		end
		report_and_stop();
	end
endmodule : tb_top
